// ==== rtl/bst_pkg.sv ====
// Shared constants and types for the board self-test sequencer and its board end
package bst_pkg;
  localparam int MEM_AW = 8;
  localparam int DW = 16;
  localparam int IC_W = 6;

  typedef enum logic [4:0] {
    T_DPR, T_VID, T_DISP, T_NVR, T_LED, T_SQ, T_SMS, T_SAT, T_PWRAP, T_UART,
    T_ATT1, T_ATT2, T_COMP, T_LODET, T_RFDET, T_DSP, T_IFBG, T_IFFG, T_IFNV
  } bst_test_type;

  typedef enum logic [3:0] {
    A_ARM, A_DECODE, A_PWRAP, A_UART, A_ATT1, A_ATT2, A_COMP, A_LODET,
    A_RF, A_DSPRST, A_DSPRDY, A_IFMEAS
  } bst_act_type;

  // APB register offsets and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_TEST = 8'h0C;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;

  // Indicator control register bits
  localparam int IC_INTERROG = 0;
  localparam int IC_REPLY = 1;
  localparam int IC_LOSC = 2;
  localparam int IC_DSPRST = 3;
  localparam int IC_PAGE2 = 4;
  localparam int IC_UARTLB = 5;

  // Gate bits in the IF measure argument
  localparam logic [15:0] G_BG = 16'h0003;
  localparam logic [15:0] G_ALL = 16'h0007;
  localparam logic [15:0] G_PULSE = 16'h0001;

  // Memory selects
  localparam logic [1:0] MS_SHARED = 2'h0;
  localparam logic [1:0] MS_VIDEO = 2'h1;
  localparam logic [1:0] MS_DISP = 2'h2;
  localparam logic [1:0] MS_NVR = 2'h3;

  localparam logic [15:0] PAT_A = 16'hAA55;
  localparam logic [15:0] PAT_B = 16'h55AA;
  localparam logic [15:0] PAT_INC_START = 16'h0000;

  // Failure codes
  localparam logic [31:0] FC_DPR = 32'h0100_0000;
  localparam logic [31:0] FC_VID = 32'h0200_0000;
  localparam logic [31:0] FC_DISP = 32'h0800_0000;
  localparam logic [31:0] FC_NVR = 32'h0040_0000;
  localparam logic [31:0] FC_LED = 32'h8000_0000;
  localparam logic [31:0] FC_SQ = 32'h0000_0400;
  localparam logic [31:0] FC_SMS = 32'h0000_0200;
  localparam logic [31:0] FC_SAT = 32'h0000_0100;
  localparam logic [31:0] FC_PWRAP = 32'h0080_0000;
  localparam logic [31:0] FC_UART = 32'h0040_0000;
  localparam logic [31:0] FC_ATT1 = 32'h1000_0000;
  localparam logic [31:0] FC_ATT2 = 32'h2000_0000;
  localparam logic [31:0] FC_COMP = 32'h4000_0000;
  localparam logic [31:0] FC_LODET = 32'h0000_0002;
  localparam logic [31:0] FC_RFDET = 32'h0000_0004;
  localparam logic [31:0] FC_DSP = 32'h0000_0040;
  localparam logic [31:0] FC_IFBG = 32'h0002_0000;
  localparam logic [31:0] FC_IFFG = 32'h0010_0000;
  localparam logic [31:0] FC_IFNV = 32'h0020_0000;

  // Test words and thresholds
  localparam logic [15:0] SQUITTER_WORD = 16'h5A11;
  localparam logic [15:0] SMS_WORD = 16'h2C3D;
  localparam logic [15:0] ATCRBS_WORD = 16'h0A73;
  localparam logic [15:0] UART_MSG = 16'hC35A;
  localparam logic [15:0] DAC_ATT1 = 16'h0155;
  localparam logic [15:0] DAC_ATT2 = 16'h02AA;
  localparam logic [15:0] DAC_COMP = 16'h0200;
  localparam logic [15:0] PWRAP_COUNTS = 16'd8;
  localparam logic [15:0] LODET_MIN = 16'd71;
  localparam logic [15:0] LODET_MAX = 16'd635;
  localparam logic [15:0] RF_ATT_DB = 16'd3;
  localparam logic [31:0] RF_RATIO_LO_X10 = 32'd16;
  localparam logic [31:0] RF_RATIO_HI_X10 = 32'd24;
  localparam logic [31:0] IF_RATIO_LO = 32'd2;
  localparam logic [31:0] IF_RATIO_HI = 32'd4;
  localparam logic [15:0] BG_MIN = 16'd100;
  localparam logic [15:0] BG_MAX = 16'd400;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int LED_WAIT_MS = 80;
  localparam int LED_WAIT_CYC = LED_WAIT_MS * 1000 * CLK_MHZ;
  localparam logic [3:0] STAT_SETTLE = 4'd4;
  localparam int DSP_BOOT_CYC = 16;
endpackage : bst_pkg

// ==== rtl/bst_link_if.sv ====
// Link between the self-test sequencer and the board it exercises
`timescale 1ns/10ps
`default_nettype none
interface bst_link_if #(parameter int AW = bst_pkg::MEM_AW);
  import bst_pkg::*;
  logic mem_req;
  logic mem_we;
  logic [1:0] mem_sel;
  logic [AW:0] mem_addr;
  logic [DW-1:0] mem_wdata;
  logic mem_ack;
  logic [DW-1:0] mem_rdata;
  logic [IC_W-1:0] ictl;
  logic [1:0] led_stat;
  logic dsp_ready;
  logic act_req;
  bst_act_type act_code;
  logic [DW-1:0] act_arg;
  logic act_ack;
  logic [DW-1:0] act_data;
  logic act_valid;
  modport seq (output mem_req, mem_we, mem_sel, mem_addr, mem_wdata, ictl, act_req,
    act_code, act_arg, input mem_ack, mem_rdata, led_stat, dsp_ready, act_ack, act_data,
    act_valid);
  modport brd (input mem_req, mem_we, mem_sel, mem_addr, mem_wdata, ictl, act_req,
    act_code, act_arg, output mem_ack, mem_rdata, led_stat, dsp_ready, act_ack, act_data,
    act_valid);
endinterface : bst_link_if
`default_nettype wire

// ==== rtl/bst_board.sv ====
// Board end: memories, indicator status, pulse generator, decoder, converters, DSP
`timescale 1ns/10ps
`default_nettype none
module bst_board import bst_pkg::*; #(
  parameter int AW = MEM_AW,
  parameter logic [15:0] LODET_LVL = 16'd300,
  parameter logic [15:0] RF_LVL0 = 16'd800,
  parameter logic [15:0] RF_LVL3 = 16'd400,
  parameter logic [15:0] BG_LVL = 16'd200,
  parameter logic [15:0] FG_LVL = 16'd900,
  parameter logic [15:0] SLS_LVL = 16'd300
) (
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic flt_en, // Corrupts bit 0 of memory reads and of decode, wrap, serial, converter and DSP ready answers
  bst_link_if.brd lk // Link to the sequencer
);
  logic [DW-1:0] mem_r [0:(4 << (AW + 1)) - 1];
  logic [7:0] boot_r;
  logic dsp_rdy;

  if (AW < 2 || AW > 14) begin : g_bad_aw
    $error("bst_board: AW out of range");
  end

  // Memory port: one-cycle ack per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk.mem_ack <= 1'b0;
      lk.mem_rdata <= '0;
    end else begin
      lk.mem_ack <= lk.mem_req && !lk.mem_ack;
      if (lk.mem_req && !lk.mem_ack) begin
        lk.mem_rdata <= mem_r[{lk.mem_sel, lk.mem_addr}] ^ {15'h0000, flt_en};
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (lk.mem_req && !lk.mem_ack && lk.mem_we) begin
      mem_r[{lk.mem_sel, lk.mem_addr}] <= lk.mem_wdata;
    end
  end

  // Indicator status follows the control bits one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk.led_stat <= 2'b00;
    end else begin
      lk.led_stat <= lk.ictl[IC_REPLY:IC_INTERROG];
    end
  end

  // DSP holds ready low through reset and its boot time
  assign dsp_rdy = (boot_r == 8'(DSP_BOOT_CYC));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_r <= 8'h00;
      lk.dsp_ready <= 1'b0;
    end else begin
      if (lk.ictl[IC_DSPRST]) begin
        boot_r <= 8'h00;
      end else if (!dsp_rdy) begin
        boot_r <= boot_r + 8'h01;
      end
      lk.dsp_ready <= dsp_rdy && !lk.ictl[IC_DSPRST];
    end
  end

  function automatic logic [DW-1:0] ifm(input logic [DW-1:0] g);
    if (g == G_BG) begin
      return BG_LVL;
    end else if (g == G_ALL) begin
      return FG_LVL;
    end
    return SLS_LVL;
  endfunction : ifm

  // Action port; the ready poll is answered only once the DSP is ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk.act_ack <= 1'b0;
      lk.act_data <= '0;
      lk.act_valid <= 1'b0;
    end else begin
      lk.act_ack <= 1'b0;
      if (lk.act_req && !lk.act_ack && (lk.act_code != A_DSPRDY || lk.dsp_ready)) begin
        lk.act_ack <= 1'b1;
        lk.act_valid <= 1'b1;
        case (lk.act_code)
          A_DECODE: lk.act_data <= mem_r[{MS_VIDEO, {(AW + 1){1'b0}}}] ^ {15'h0000, flt_en};
          A_PWRAP: lk.act_data <= PWRAP_COUNTS ^ {15'h0000, flt_en};
          A_UART: lk.act_data <= lk.ictl[IC_UARTLB] ? lk.act_arg ^ {15'h0000, flt_en} : '0;
          A_ATT1, A_ATT2, A_COMP: lk.act_data <= lk.act_arg ^ {15'h0000, flt_en};
          A_LODET: lk.act_data <= lk.ictl[IC_LOSC] ? LODET_LVL : '0;
          A_RF: lk.act_data <= (lk.act_arg == 16'h0000) ? RF_LVL0 : RF_LVL3;
          A_DSPRDY: lk.act_data <= {15'h0000, lk.dsp_ready && !flt_en};
          A_IFMEAS: begin
            lk.act_valid <= lk.ictl[IC_LOSC];
            lk.act_data <= lk.ictl[IC_LOSC] ? ifm(lk.act_arg) : '0;
          end
          default: lk.act_data <= '0;
        endcase
      end
    end
  end
endmodule : bst_board
`default_nettype wire

// ==== rtl/bst_sequencer.sv ====
// Self-test sequencer with APB control and status registers
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Video memory tested like shared buffer memory
// - Display test uses copied secondary page, restores
// - Non-volatile memory saved, tested, then restored
// - Indicators on, verified, off verified 80 ms later
// - Squitter loaded to video memory, decoded, compared
// - Solicited Mode S: arm decoder, then decode
// - Solicited ATCRBS reply armed, decoded, compared
// - Pulse spacing must measure eight timer counts
// - UART loopback message must come back intact
// - Attenuator converters read back through ADC
// - Compensation converter read back through ADC
// - Lock detect reading must be 71 to 635
// - RF ratio, 0 over 3 dB, is 2+-0.4
// - Reset DSP, then check its ready status
// - Background loop level checked with pulse, sidelobe 0
// - Foreground over sidelobe ratio is 3+-1
// - Oscillator off: valid measurement means failure
// - Pattern fill AA55, 55AA, incrementing from 0000
// - Shared memory failure skips to indicator test
// - Result is the sum of failing codes
module bst_sequencer import bst_pkg::*; #(
  parameter int AW = MEM_AW,
  parameter int unsigned LED_WAIT = LED_WAIT_CYC
) (
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  bst_link_if.seq lk // Link to the board
);
  typedef enum logic [3:0] {
    S_IDLE, S_START, S_MISSUE, S_MWAIT, S_LED_ON, S_LED_WAIT, S_ACT, S_LOAD_W,
    S_ACT_W, S_EVAL
  } bst_state_type;

  bst_state_type state_r;
  bst_test_type tidx_r;
  logic [2:0] ph_r;
  logic [AW-1:0] addr_r;
  logic cp_wr_r;
  logic [DW-1:0] hold_r;
  logic ld_r;
  logic fail_r;
  logic [31:0] cnt_r;
  logic [DW-1:0] m1_r;
  logic [DW-1:0] dat_r;
  logic val_r;
  logic [31:0] acc_r;
  logic done_r;
  logic start_p;
  logic copy_ph;
  logic chk_ph;
  logic tfail;
  logic [DW-1:0] pat;
  bst_act_type act;

  if (AW < 2 || AW > 14 || LED_WAIT < 1) begin : g_bad_par
    $error("bst_sequencer: parameter out of range");
  end

  function automatic logic reg_hit(input logic [7:0] a);
    return a == REG_CTRL || a == REG_STATUS || a == REG_RESULT || a == REG_TEST;
  endfunction : reg_hit

  function automatic logic two_ph(input bst_test_type t);
    return t == T_SMS || t == T_SAT || t == T_RFDET || t == T_DSP || t == T_IFFG;
  endfunction : two_ph

  function automatic logic is_mem(input bst_test_type t);
    return t == T_DPR || t == T_VID || t == T_DISP || t == T_NVR;
  endfunction : is_mem

  function automatic logic saves(input bst_test_type t);
    return t == T_DISP || t == T_NVR;
  endfunction : saves

  function automatic bst_act_type act_of(input bst_test_type t, input logic p);
    case (t)
      T_SQ: return A_DECODE;
      T_SMS, T_SAT: return p ? A_DECODE : A_ARM;
      T_PWRAP: return A_PWRAP;
      T_UART: return A_UART;
      T_ATT1: return A_ATT1;
      T_ATT2: return A_ATT2;
      T_COMP: return A_COMP;
      T_LODET: return A_LODET;
      T_RFDET: return A_RF;
      T_DSP: return p ? A_DSPRDY : A_DSPRST;
      default: return A_IFMEAS;
    endcase
  endfunction : act_of

  function automatic logic [DW-1:0] arg_of(input bst_test_type t, input logic p);
    case (t)
      T_SQ: return SQUITTER_WORD;
      T_SMS: return p ? SMS_WORD : 16'h0000;
      T_SAT: return p ? ATCRBS_WORD : 16'h0001;
      T_UART: return UART_MSG;
      T_ATT1: return DAC_ATT1;
      T_ATT2: return DAC_ATT2;
      T_COMP: return DAC_COMP;
      T_RFDET: return p ? RF_ATT_DB : 16'h0000;
      T_IFBG: return G_BG;
      T_IFFG: return p ? G_PULSE : G_ALL;
      T_IFNV: return G_ALL;
      default: return 16'h0000;
    endcase
  endfunction : arg_of

  function automatic logic [31:0] code_of(input bst_test_type t);
    case (t)
      T_DPR: return FC_DPR;
      T_VID: return FC_VID;
      T_DISP: return FC_DISP;
      T_NVR: return FC_NVR;
      T_LED: return FC_LED;
      T_SQ: return FC_SQ;
      T_SMS: return FC_SMS;
      T_SAT: return FC_SAT;
      T_PWRAP: return FC_PWRAP;
      T_UART: return FC_UART;
      T_ATT1: return FC_ATT1;
      T_ATT2: return FC_ATT2;
      T_COMP: return FC_COMP;
      T_LODET: return FC_LODET;
      T_RFDET: return FC_RFDET;
      T_DSP: return FC_DSP;
      T_IFBG: return FC_IFBG;
      T_IFFG: return FC_IFFG;
      default: return FC_IFNV;
    endcase
  endfunction : code_of

  function automatic logic pass_of(input bst_test_type t, input logic [DW-1:0] m1,
      input logic [DW-1:0] d, input logic v, input logic rdy);
    logic [31:0] a;
    logic [31:0] b;
    a = {16'h0000, m1};
    b = {16'h0000, d};
    case (t)
      T_SQ, T_SMS, T_SAT: return d == arg_of(t, two_ph(t));
      T_PWRAP: return d == PWRAP_COUNTS;
      T_UART: return d == UART_MSG;
      T_ATT1, T_ATT2, T_COMP: return d == arg_of(t, 1'b0);
      T_LODET: return d >= LODET_MIN && d <= LODET_MAX;
      T_RFDET: return a * 32'd10 >= b * RF_RATIO_LO_X10 && a * 32'd10 <= b * RF_RATIO_HI_X10;
      T_DSP: return d[0] && rdy;
      T_IFBG: return v && d >= BG_MIN && d <= BG_MAX;
      T_IFFG: return v && a >= b * IF_RATIO_LO && a <= b * IF_RATIO_HI;
      T_IFNV: return !v;
      default: return 1'b1;
    endcase
  endfunction : pass_of

  assign start_p = psel && penable && pready && pwrite && paddr == REG_CTRL
    && pwdata[CTRL_START_BIT] && state_r == S_IDLE;
  assign copy_ph = ph_r == 3'd0 || ph_r == 3'd7;
  assign chk_ph = ph_r == 3'd2 || ph_r == 3'd4 || ph_r == 3'd6;
  assign act = act_of(tidx_r, ph_r[0]);
  assign tfail = fail_r || !pass_of(tidx_r, m1_r, dat_r, val_r, lk.dsp_ready);
  always_comb begin
    if (ph_r <= 3'd2) begin
      pat = PAT_A;
    end else if (ph_r <= 3'd4) begin
      pat = PAT_B;
    end else begin
      pat = PAT_INC_START + DW'(addr_r);
    end
  end

  // APB slave: one wait state, write takes effect on the ready edge, read data is latched one edge earlier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !reg_hit(paddr);
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          REG_STATUS: prdata <= {30'h0, done_r, state_r != S_IDLE};
          REG_RESULT: prdata <= acc_r;
          REG_TEST: prdata <= {27'h0, tidx_r};
          default: prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      tidx_r <= T_DPR;
      ph_r <= 3'd0;
      addr_r <= '0;
      cp_wr_r <= 1'b0;
      hold_r <= '0;
      ld_r <= 1'b0;
      fail_r <= 1'b0;
      cnt_r <= '0;
      m1_r <= '0;
      dat_r <= '0;
      val_r <= 1'b0;
      acc_r <= RESULT_RST;
      done_r <= 1'b0;
      lk.mem_req <= 1'b0;
      lk.mem_we <= 1'b0;
      lk.mem_sel <= MS_SHARED;
      lk.mem_addr <= '0;
      lk.mem_wdata <= '0;
      lk.ictl <= '0;
      lk.act_req <= 1'b0;
      lk.act_code <= A_ARM;
      lk.act_arg <= '0;
    end else begin
      case (state_r)
        S_IDLE: if (start_p) begin
          tidx_r <= T_DPR;
          acc_r <= RESULT_RST;
          done_r <= 1'b0;
          state_r <= S_START;
        end
        S_START: begin
          addr_r <= '0;
          ph_r <= (is_mem(tidx_r) && !saves(tidx_r)) ? 3'd1 : 3'd0;
          ld_r <= 1'b0;
          fail_r <= 1'b0;
          cnt_r <= '0;
          val_r <= 1'b0;
          lk.ictl[IC_LOSC] <= tidx_r == T_LODET || tidx_r == T_RFDET || tidx_r == T_IFBG
            || tidx_r == T_IFFG;
          lk.ictl[IC_UARTLB] <= tidx_r == T_UART;
          if (is_mem(tidx_r)) begin
            state_r <= S_MISSUE;
          end else if (tidx_r == T_LED) begin
            lk.ictl[IC_REPLY:IC_INTERROG] <= 2'b11;
            state_r <= S_LED_ON;
          end else begin
            state_r <= S_ACT;
          end
        end
        S_MISSUE: begin
          // Save copies target to backup, restore copies back; display backup is page 2
          lk.mem_req <= 1'b1;
          lk.mem_we <= copy_ph ? cp_wr_r : !chk_ph;
          lk.mem_wdata <= copy_ph ? hold_r : pat;
          if (copy_ph && ((ph_r == 3'd0) == cp_wr_r)) begin
            lk.mem_sel <= tidx_r == T_DISP ? MS_DISP : MS_SHARED;
            lk.mem_addr <= {tidx_r == T_DISP, addr_r};
          end else begin
            lk.mem_sel <= tidx_r == T_VID ? MS_VIDEO : tidx_r == T_DISP ? MS_DISP
              : tidx_r == T_NVR ? MS_NVR : MS_SHARED;
            lk.mem_addr <= {1'b0, addr_r};
          end
          state_r <= S_MWAIT;
        end
        S_MWAIT: if (lk.mem_ack) begin
          lk.mem_req <= 1'b0;
          state_r <= S_MISSUE;
          if (copy_ph && !cp_wr_r) begin
            hold_r <= lk.mem_rdata;
            cp_wr_r <= 1'b1;
          end else begin
            cp_wr_r <= 1'b0;
            if (chk_ph && lk.mem_rdata != pat) begin
              fail_r <= 1'b1;
            end
            addr_r <= addr_r + 1'b1;
            if (&addr_r) begin
              ph_r <= ph_r + 3'd1;
              if (ph_r == 3'd0 && tidx_r == T_DISP) begin
                lk.ictl[IC_PAGE2] <= 1'b1;
              end
              if (ph_r == 3'd7 || (ph_r == 3'd6 && !saves(tidx_r))) begin
                lk.ictl[IC_PAGE2] <= 1'b0;
                state_r <= S_EVAL;
              end
            end
          end
        end
        S_LED_ON: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == 32'(STAT_SETTLE)) begin
            fail_r <= lk.led_stat != 2'b11;
            lk.ictl[IC_REPLY:IC_INTERROG] <= 2'b00;
            cnt_r <= '0;
            state_r <= S_LED_WAIT;
          end
        end
        S_LED_WAIT: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == LED_WAIT - 1) begin
            if (lk.led_stat != 2'b00) begin
              fail_r <= 1'b1;
            end
            state_r <= S_EVAL;
          end
        end
        S_ACT: if (act == A_DECODE && !ld_r) begin
          lk.mem_req <= 1'b1;
          lk.mem_we <= 1'b1;
          lk.mem_sel <= MS_VIDEO;
          lk.mem_addr <= '0;
          lk.mem_wdata <= arg_of(tidx_r, ph_r[0]);
          state_r <= S_LOAD_W;
        end else begin
          lk.act_req <= 1'b1;
          lk.act_code <= act;
          lk.act_arg <= arg_of(tidx_r, ph_r[0]);
          lk.ictl[IC_DSPRST] <= act == A_DSPRST;
          state_r <= S_ACT_W;
        end
        S_LOAD_W: if (lk.mem_ack) begin
          lk.mem_req <= 1'b0;
          ld_r <= 1'b1;
          state_r <= S_ACT;
        end
        S_ACT_W: if (lk.act_ack) begin
          lk.act_req <= 1'b0;
          lk.ictl[IC_DSPRST] <= 1'b0;
          if (two_ph(tidx_r) && ph_r == 3'd0) begin
            m1_r <= lk.act_data;
            ph_r <= 3'd1;
            state_r <= S_ACT;
          end else begin
            dat_r <= lk.act_data;
            val_r <= lk.act_valid;
            state_r <= S_EVAL;
          end
        end
        S_EVAL: begin
          if (tfail) begin
            acc_r <= acc_r + code_of(tidx_r);
          end
          state_r <= S_START;
          if (tidx_r == T_DPR && tfail) begin
            tidx_r <= T_LED;
          end else if (tidx_r == T_IFNV) begin
            lk.ictl <= '0;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            tidx_r <= bst_test_type'(tidx_r + 5'd1);
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule : bst_sequencer
`default_nettype wire

// ==== test/bst_link_sva.sv ====
// Checker of the link between the self-test sequencer and its board end
`timescale 1ns/10ps
`default_nettype none
module bst_link_sva import bst_pkg::*; #(
  parameter int AW = MEM_AW
) (
  input wire logic pclk, // Processor clock
  input wire logic presetn, // Reset, active low
  input wire logic mem_req, // Memory request
  input wire logic mem_ack, // Memory answer
  input wire logic mem_we, // Memory write
  input wire logic [1:0] mem_sel, // Memory select
  input wire logic [AW:0] mem_addr, // Memory address
  input wire logic [IC_W-1:0] ictl, // Indicator control
  input wire logic [1:0] led_stat, // Indicator status
  input wire logic dsp_ready, // DSP ready
  input wire logic act_req, // Action request
  input wire bst_act_type act_code, // Action code
  input wire logic act_ack // Action answer
);
  logic prim_wr;
  // Primary display page is only ever written while the secondary page is shown
  assign prim_wr = mem_req && mem_we && mem_sel == MS_DISP && !mem_addr[AW];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_req_kept;
    mem_req && $stable(mem_addr) && $stable(mem_sel);
  endsequence
  sequence s_mem_close;
    mem_ack ##1 !mem_ack && !mem_req;
  endsequence
  sequence s_act_close;
    act_ack ##1 !act_ack && !act_req;
  endsequence
  AST_MEM_ONE: assert property (mem_ack |-> s_mem_close)
    else $error("memory answer not a single pulse");
  AST_MEM_WAIT: assert property ($rose(mem_req) |=> mem_ack)
    else $error("memory answer late");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> s_req_kept)
    else $error("memory request changed while pending");
  AST_ACT_WAIT: assert property ($rose(act_req) && act_code != A_DSPRDY |=> act_ack)
    else $error("action answer late");
  AST_ACT_ONE: assert property (act_ack |-> s_act_close)
    else $error("action answer not a single pulse");
  AST_RDY_GATE: assert property (act_ack && act_code == A_DSPRDY |-> $past(dsp_ready))
    else $error("ready answered without ready");
  AST_LED_ECHO: assert property (led_stat == $past(ictl[1:0]))
    else $error("indicator status not following control");
  AST_UART_LOOP: assert property (act_req && act_code == A_UART |-> ictl[IC_UARTLB])
    else $error("serial test without loopback");
  AST_LOSC_ON: assert property (act_req && act_code == A_LODET |-> ictl[IC_LOSC])
    else $error("lock test with oscillator off");
  AST_DSP_RST: assert property (act_req && act_code == A_DSPRST |-> ictl[IC_DSPRST])
    else $error("DSP reset action without reset bit");
  AST_PAGE_VIS: assert property (prim_wr |-> ictl[IC_PAGE2])
    else $error("primary display page written while visible");
endmodule : bst_link_sva
`default_nettype wire

// ==== test/board_self_test_sequencer_tb.sv ====
// Testbench for the board self-test sequencer and its board end
`timescale 1ns/10ps
`default_nettype none
module board_self_test_sequencer_tb;
  import bst_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, flt_en, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr;
  int err_total, n_checks;
  logic [31:0] fails[$];
  bst_link_if i_bst_link_if ();
  bst_sequencer #(.LED_WAIT(20)) i_bst_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lk(i_bst_link_if));
  bst_board i_bst_board (.pclk(pclk), .presetn(presetn), .flt_en(flt_en), .lk(i_bst_link_if));
  bst_link_sva i_bst_link_sva (.pclk(pclk), .presetn(presetn),
    .mem_req(i_bst_link_if.mem_req), .mem_ack(i_bst_link_if.mem_ack),
    .mem_we(i_bst_link_if.mem_we),
    .mem_sel(i_bst_link_if.mem_sel), .mem_addr(i_bst_link_if.mem_addr),
    .ictl(i_bst_link_if.ictl), .led_stat(i_bst_link_if.led_stat),
    .dsp_ready(i_bst_link_if.dsp_ready), .act_req(i_bst_link_if.act_req),
    .act_code(i_bst_link_if.act_code), .act_ack(i_bst_link_if.act_ack));
  task automatic close_out();
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One idle cycle at the end keeps two transfers from driving psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic run(input logic f);
    logic [31:0] last;
    logic busy;
    flt_en <= f;
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("busy", 32'(rd[STAT_BUSY_BIT]), 32'h1);
    last = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      busy = rd[STAT_BUSY_BIT];
      apb(1'b0, REG_TEST, 32'h0);
      chk("order", 32'(rd >= last || rd == 0), 32'h1);
      if (f) chk("skip", 32'(rd inside {[1:3]}), 32'h0);
      last = rd;
    end while (busy === 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("done", 32'(rd[STAT_DONE_BIT]), 32'h1);
    apb(1'b0, REG_RESULT, 32'h0);
    chk("result", rd, fails.sum());
  endtask : run
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (90000) @(posedge pclk);
    err_total++;
    close_out();
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    flt_en = 1'b0;
    presetn = 1'b0;
    void'($urandom(92));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_RESULT, 32'h0);
    chk("result reset", rd, RESULT_RST);
    chk("mapped err", 32'(er), 32'h0);
    repeat (4) begin
      apb(1'b1, 8'h10 + 8'(($urandom % 60) * 4), $urandom);
      chk("unmapped err", 32'(er), 32'h1);
      apb(1'b0, 8'h10 + 8'(($urandom % 60) * 4), 32'h0);
      chk("unmapped data", rd, 32'h0);
    end
    fails = {};
    run(1'b0);
    // Corrupted answers fail shared memory, decoders, wrap, serial, converters and DSP
    fails = '{FC_DPR, FC_SQ, FC_SMS, FC_SAT, FC_PWRAP, FC_UART, FC_ATT1, FC_ATT2, FC_COMP,
      FC_DSP};
    run(1'b1);
    close_out();
  end
endmodule : board_self_test_sequencer_tb
`default_nettype wire
